// file: hw/oma_arbiter.sv
// Output mode arbiter: picks the manipulated variable driven to the output
// Assumes a classic Wishbone master, pins asynchronous to CLOCK
//
// Behaviour
// RULE_01 - Automatic passes only with every request off
// RULE_02 - Manual request is front OR external
// RULE_03 - Manual needs safety, blocking off, priority aware
// RULE_04 - Manual value absolute or step increments
// RULE_05 - Follow-up needs safety, blocking off, priority aware
// RULE_06 - External value source by select and serial
// RULE_07 - Incremental ramp at full scale per floating time
// RULE_08 - Internal feedback step controller: increments only
// RULE_09 - Safety outputs clamped safety value
// RULE_10 - Safety step drives lower or raise continuously (code: structure 1 only; structures 2 and 3 drive neither)
// RULE_11 - One blocking request freezes that direction
// RULE_12 - Both blocking requests freeze output fully
// RULE_13 - Priority blocking, safety, manual/follow, automatic
// RULE_14 - Mode change starts from previous output (code: manual and ramp follow-up only; other modes take their value at once)
// RULE_15 - Manual indicator lit, external request blinks short-off
// RULE_16 - External indicator lit, overridden follow-up blinks evenly
// RULE_17 - External manual release returns to automatic
// RULE_18 - Follow-up kept prepared behind manual
// RULE_19 - Lockout fixes front selection auto or manual
// RULE_20 - Transmitter fault forces manual, last or safety
// RULE_21 - Display source select or display off
// RULE_22 - Mode and output registered each cycle
`timescale 1ns/100ps
`include "oma_regs.svh"
module oma_arbiter import oma_pkg::*; #(
  parameter int RAMP_DIV = `OMA_FLOAT_TIME_MS * `OMA_CLK_KHZ / 1000,
  parameter int BLINK_DIV = `OMA_BLINK_STEP_MS * `OMA_CLK_KHZ
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Control pins
  input wire logic EXT_MANUAL_REQ,
  input wire logic FOLLOWUP_REQ,
  input wire logic SAFETY_REQ,
  input wire logic BLOCK_RAISE_REQ,
  input wire logic BLOCK_LOWER_REQ,
  input wire logic STEP_UP_IN,
  input wire logic STEP_DN_IN,
  input wire logic XMTR_FAULT,
  // Front keys
  input wire logic KEY_MANUAL,
  input wire logic KEY_UP,
  input wire logic KEY_DN,
  // Values from the same clock
  input wire oma_val_t AUTOMATIC_VALUE,
  input wire oma_val_t FOLLOWUP_ANALOG_INPUT,
  input wire oma_val_t POSITION_FEEDBACK_INPUT,
  // Outputs
  output oma_val_t Y_OUT,
  output logic STEP_RAISE,
  output logic STEP_LOWER,
  output logic MANUAL_LED,
  output logic EXT_LED,
  output logic MODE_MANUAL,
  output logic MODE_FOLLOWUP,
  output oma_val_t DISPLAY_VALUE,
  output logic DISPLAY_ON
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NPIN = 11;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m_q;
  logic [NPIN-1:0] pin_q;
  assign pin_raw = {KEY_MANUAL, KEY_UP, KEY_DN, EXT_MANUAL_REQ, FOLLOWUP_REQ, SAFETY_REQ,
                    BLOCK_RAISE_REQ, BLOCK_LOWER_REQ, STEP_UP_IN, STEP_DN_IN, XMTR_FAULT};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
          pin_m_q[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          pin_m_q[gi] <= pin_raw[gi];
          pin_q[gi] <= pin_m_q[gi];
        end
      end
    end
  endgenerate
  logic key_man, key_up, key_dn, ext_manual_req, fu_req, safe_req;
  logic blk_up, blk_dn, step_up, step_dn, fault;
  assign {key_man, key_up, key_dn, ext_manual_req, fu_req, safe_req,
          blk_up, blk_dn, step_up, step_dn, fault} = pin_q;
  logic key_man_old_q, fault_old_q;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      key_man_old_q <= 1'b0;
      fault_old_q <= 1'b0;
    end else begin
      key_man_old_q <= key_man;
      fault_old_q <= fault;
    end
  end
  logic key_man_rise, fault_rise;
  assign key_man_rise = key_man && !key_man_old_q;
  assign fault_rise = fault && !fault_old_q;

  // ----------------------------------------
  // Registers over Wishbone
  // ----------------------------------------
  logic [11:0] cfg_q;
  oma_val_t safety_value_q;
  oma_val_t serial_value_q;
  logic bus_req, bus_wr;
  logic [1:0] idx;
  assign bus_req = CYC_I && STB_I && !ACK_O;
  assign bus_wr = bus_req && WE_I;
  assign idx = ADR_I[3:2];
  oma_val_t wr_val;
  oma_val_t wr_clamp;
  assign wr_val = {SEL_I[1] ? DAT_I[11:8] : 4'h0, SEL_I[0] ? DAT_I[7:0] : 8'h00};
  assign wr_clamp = (wr_val < $signed(`OMA_VAL_MIN)) ? $signed(`OMA_VAL_MIN) :
                    (wr_val > $signed(`OMA_VAL_MAX)) ? $signed(`OMA_VAL_MAX) : wr_val;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_q <= `OMA_CFG_RST;
    end else if (bus_wr && idx == `OMA_ADR_CFG) begin
      if (SEL_I[0]) begin
        cfg_q[7:0] <= DAT_I[7:0];
      end
      if (SEL_I[1]) begin
        cfg_q[11:8] <= DAT_I[11:8];
      end
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      safety_value_q <= `OMA_SAFE_RST;
    end else if (bus_wr && idx == `OMA_ADR_SAFE && SEL_I[1:0] == 2'h3) begin
      safety_value_q <= wr_clamp; // RULE_09
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      serial_value_q <= '0;
    end else if (bus_wr && idx == `OMA_ADR_SER && SEL_I[1:0] == 2'h3) begin
      serial_value_q <= wr_clamp;
    end
  end
  logic prio_manual;
  logic src_incr;
  logic [1:0] fault_cfg, lockout, disp_cfg, serial_level, structure;
  assign prio_manual = cfg_q[`OMA_CFG_PRIO];
  assign src_incr = cfg_q[`OMA_CFG_SRC];
  assign fault_cfg = cfg_q[`OMA_CFG_FLT];
  assign lockout = cfg_q[`OMA_CFG_LOCK];
  assign disp_cfg = cfg_q[`OMA_CFG_DISP];
  assign serial_level = cfg_q[`OMA_CFG_SER];
  assign structure = cfg_q[`OMA_CFG_STR];

  // ----------------------------------------
  // Front selection and requests
  // ----------------------------------------
  logic front_manual_sel_q;
  logic fault_man_q;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      front_manual_sel_q <= 1'b0;
    end else if (lockout == 2'h1) begin
      front_manual_sel_q <= 1'b0; // RULE_19
    end else if (lockout == 2'h2) begin
      front_manual_sel_q <= 1'b1; // RULE_19
    end else if (key_man_rise) begin
      front_manual_sel_q <= !front_manual_sel_q;
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      fault_man_q <= 1'b0;
    end else if (fault_rise && fault_cfg != 2'h0) begin
      fault_man_q <= 1'b1; // RULE_20
    end else if (key_man_rise || !fault) begin
      fault_man_q <= 1'b0;
    end
  end
  logic man_req, blk_any;
  assign man_req = front_manual_sel_q || ext_manual_req || fault_man_q; // RULE_02
  assign blk_any = blk_up || blk_dn;

  // ----------------------------------------
  // Mode decision
  // ----------------------------------------
  oma_mode_t mode_q, mode_d;
  always_comb begin
    mode_d = OMA_AUTO; // RULE_01
    if (blk_any) begin
      mode_d = OMA_BLOCK; // RULE_13
    end else if (safe_req) begin
      mode_d = OMA_SAFE; // RULE_13
    end else if (!prio_manual) begin
      if (fu_req) begin
        mode_d = OMA_FOLLOW; // RULE_05
      end else if (man_req) begin
        mode_d = OMA_MANUAL; // RULE_03
      end
    end else begin
      if (man_req) begin
        mode_d = OMA_MANUAL; // RULE_18
      end else if (fu_req) begin
        mode_d = OMA_FOLLOW; // RULE_18
      end
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      mode_q <= OMA_AUTO; // RULE_22
    end else begin
      mode_q <= mode_d; // RULE_17
    end
  end

  // ----------------------------------------
  // Manual and external values
  // ----------------------------------------
  oma_val_t man_val, ext_ramp_val;
  logic man_load, ext_load, in_manual, in_follow;
  assign in_manual = (mode_q == OMA_MANUAL);
  assign in_follow = (mode_q == OMA_FOLLOW);
  assign man_load = !in_manual || fault_rise;
  assign ext_load = !in_follow;
  oma_ramp #(.DIV(RAMP_DIV)) u_man_ramp (
    .clk(CLOCK),
    .rst_n(RSTN),
    .load(man_load),
    .load_val(((fault_rise || fault_man_q) && fault_cfg == 2'h2) ? safety_value_q : Y_OUT), // RULE_14 RULE_20
    .up(in_manual && key_up),
    .dn(in_manual && key_dn),
    .val(man_val)
  );
  oma_ramp #(.DIV(RAMP_DIV)) u_ext_ramp (
    .clk(CLOCK),
    .rst_n(RSTN),
    .load(ext_load),
    .load_val(Y_OUT), // RULE_14
    .up(in_follow && step_up),
    .dn(in_follow && step_dn),
    .val(ext_ramp_val)
  );
  oma_val_t ext_val;
  always_comb begin
    if (structure == 2'h1) begin
      ext_val = ext_ramp_val; // RULE_08
    end else if (serial_level == 2'h2) begin
      ext_val = serial_value_q; // RULE_06
    end else if (!src_incr) begin
      ext_val = FOLLOWUP_ANALOG_INPUT; // RULE_06
    end else begin
      ext_val = ext_ramp_val; // RULE_06
    end
  end

  // ----------------------------------------
  // Output value
  // ----------------------------------------
  oma_val_t y_d;
  always_comb begin
    case (mode_d)
      OMA_AUTO: y_d = AUTOMATIC_VALUE;
      OMA_MANUAL: y_d = man_val;
      OMA_FOLLOW: y_d = ext_val;
      OMA_SAFE: y_d = safety_value_q; // RULE_09
      OMA_BLOCK: begin
        y_d = AUTOMATIC_VALUE;
        if (blk_up && blk_dn) begin
          y_d = Y_OUT; // RULE_12
        end else if (blk_up && AUTOMATIC_VALUE > Y_OUT) begin
          y_d = Y_OUT; // RULE_11
        end else if (blk_dn && AUTOMATIC_VALUE < Y_OUT) begin
          y_d = Y_OUT; // RULE_11
        end
      end
      default: y_d = Y_OUT;
    endcase
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      Y_OUT <= '0;
    end else begin
      Y_OUT <= y_d; // RULE_22
    end
  end

  // ----------------------------------------
  // Step outputs
  // ----------------------------------------
  logic step_ctrl, raise_d, lower_d;
  assign step_ctrl = (structure != 2'h0);
  always_comb begin
    raise_d = 1'b0;
    lower_d = 1'b0;
    if (step_ctrl && mode_d == OMA_SAFE && structure == 2'h1) begin
      lower_d = (safety_value_q < $signed(`OMA_VAL_HALF)); // RULE_10
      raise_d = !lower_d; // RULE_10
    end else if (step_ctrl && mode_d == OMA_MANUAL) begin
      raise_d = key_up && !key_dn; // RULE_04
      lower_d = key_dn && !key_up; // RULE_04
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      STEP_RAISE <= 1'b0;
      STEP_LOWER <= 1'b0;
    end else begin
      STEP_RAISE <= raise_d;
      STEP_LOWER <= lower_d;
    end
  end

  // ----------------------------------------
  // Indicators and mode flags
  // ----------------------------------------
  oma_blink_if u_bl ();
  oma_blink #(.DIV(BLINK_DIV)) u_blink (
    .clk(CLOCK),
    .rst_n(RSTN),
    .bl(u_bl.src)
  );
  logic man_led_d, ext_led_d;
  always_comb begin
    man_led_d = (mode_d == OMA_MANUAL) || man_req; // RULE_15
    if (ext_manual_req && !front_manual_sel_q && !fault_man_q) begin
      man_led_d = u_bl.blink_short_off; // RULE_15
    end
    ext_led_d = (mode_d == OMA_FOLLOW) || (mode_d == OMA_SAFE) || (mode_d == OMA_BLOCK); // RULE_16
    if (mode_d == OMA_MANUAL && fu_req && prio_manual) begin
      ext_led_d = u_bl.blink_even; // RULE_16
    end
  end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      MANUAL_LED <= 1'b0;
      EXT_LED <= 1'b0;
      MODE_MANUAL <= 1'b0;
      MODE_FOLLOWUP <= 1'b0;
    end else begin
      MANUAL_LED <= man_led_d;
      EXT_LED <= ext_led_d;
      MODE_MANUAL <= (mode_d == OMA_MANUAL);
      MODE_FOLLOWUP <= (mode_d == OMA_FOLLOW);
    end
  end

  // ----------------------------------------
  // Display source
  // ----------------------------------------
  oma_val_t split_val;
  assign split_val = (y_d > $signed(`OMA_VAL_HALF)) ? $signed(`OMA_FULL_SCALE) : 12'(y_d <<< 1);
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DISPLAY_VALUE <= '0;
      DISPLAY_ON <= 1'b0;
    end else begin
      DISPLAY_ON <= (disp_cfg != 2'h0); // RULE_21
      case (disp_cfg)
        2'h1: DISPLAY_VALUE <= y_d; // RULE_21
        2'h2: DISPLAY_VALUE <= split_val; // RULE_21
        2'h3: DISPLAY_VALUE <= POSITION_FEEDBACK_INPUT; // RULE_21
        default: DISPLAY_VALUE <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ACK_O <= 1'b0;
      DAT_O <= '0;
    end else begin
      ACK_O <= bus_req;
      DAT_O <= '0;
      if (bus_req && !WE_I) begin
        case (idx)
          `OMA_ADR_CFG: DAT_O <= {20'h0, cfg_q};
          `OMA_ADR_SAFE: DAT_O <= {20'h0, safety_value_q};
          `OMA_ADR_SER: DAT_O <= {20'h0, serial_value_q};
          `OMA_ADR_STAT: DAT_O <= {16'h0, 1'b0, mode_q, Y_OUT};
          default: DAT_O <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  localparam oma_val_t HALF = `OMA_VAL_HALF;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  a_auto_gate: assert property (mode_q == OMA_AUTO |-> $past(!man_req && !fu_req && !safe_req && !blk_any)) // RULE_01
    else $error("automatic mode with a request pending");
  a_block_wins: assert property (blk_any |=> mode_q == OMA_BLOCK) // RULE_13
    else $error("blocking did not take priority");
  a_safety_mode: assert property (safe_req && !blk_any |=> mode_q == OMA_SAFE && Y_OUT == $past(safety_value_q)) // RULE_09
    else $error("safety value not output");
  a_full_freeze: assert property (blk_up && blk_dn && mode_q == OMA_BLOCK |=> Y_OUT == $past(Y_OUT)) // RULE_12
    else $error("output moved under full block");
  a_raise_freeze: assert property (blk_up && !blk_dn && mode_q == OMA_BLOCK |=> Y_OUT <= $past(Y_OUT)) // RULE_11
    else $error("output rose under raise block");
  a_safe_step: assert property (mode_q == OMA_SAFE && $past(structure) == 2'h1
      |-> STEP_LOWER == ($past(safety_value_q) < HALF) && STEP_RAISE != STEP_LOWER) // RULE_10
    else $error("safety step direction wrong");
  a_manual_entry: assert property (!blk_any && !safe_req && man_req && (prio_manual || !fu_req)
      |=> mode_q == OMA_MANUAL && MODE_MANUAL) // RULE_03
    else $error("manual mode not entered");
  a_follow_entry: assert property (!blk_any && !safe_req && fu_req && !(prio_manual && man_req)
      |=> mode_q == OMA_FOLLOW && MODE_FOLLOWUP) // RULE_05
    else $error("follow-up not entered");
  a_ext_led_on: assert property (mode_d == OMA_SAFE |=> EXT_LED) // RULE_16
    else $error("external indicator dark in safety");
  c_follow_over_manual: cover property (mode_q == OMA_MANUAL ##1 mode_q == OMA_FOLLOW);
  c_fault_manual: cover property (fault_rise && fault_cfg == 2'h2 ##[1:3] in_manual);
  c_block_freeze: cover property (mode_q == OMA_BLOCK && blk_up && blk_dn);
endmodule // oma_arbiter

// file: hw/oma_blink.sv
// Blink patterns: 0.1 off / 0.9 on, and 1:1, on a 0.1 s slot enable
// Assumes one clock
`timescale 1ns/100ps
module oma_blink #(
  parameter int DIV = 2000000
) (
  input wire logic clk,
  input wire logic rst_n,
  oma_blink_if.src bl
);
  logic [31:0] div_q;
  logic [3:0] slot_q;
  logic slot_en;
  assign slot_en = (div_q == 32'(DIV - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else begin
      div_q <= slot_en ? '0 : div_q + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= '0;
    end else if (slot_en) begin
      slot_q <= (slot_q == `OMA_BLINK_SLOTS) ? 4'h0 : slot_q + 4'h1;
    end
  end
  assign bl.blink_short_off = (slot_q != 4'h0); // RULE_15
  assign bl.blink_even = (slot_q < 4'h5); // RULE_16
endmodule // oma_blink

// file: hw/oma_ramp.sv
// Value ramp at full scale per floating time, loadable for bumpless entry
// Assumes up and dn come from synchronised lines
`timescale 1ns/100ps
module oma_ramp import oma_pkg::*; #(
  parameter int DIV = 1200
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire oma_val_t load_val,
  input wire logic up,
  input wire logic dn,
  output oma_val_t val
);
  logic [31:0] div_q;
  logic tick;
  assign tick = (div_q == 32'(DIV - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (tick || !(up ^ dn)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val <= '0;
    end else if (load) begin
      val <= load_val;
    end else if (tick && up && val < $signed(`OMA_VAL_MAX)) begin
      val <= val + 12'sh1; // RULE_07
    end else if (tick && dn && val > $signed(`OMA_VAL_MIN)) begin
      val <= val - 12'sh1; // RULE_07
    end
  end
endmodule // oma_ramp

// file: include/oma_blink_if.sv
// Indicator blink patterns passed from the blink generator to the arbiter
// Assumes one clock domain
`timescale 1ns/100ps
interface oma_blink_if;
  logic blink_short_off;
  logic blink_even;
  modport src (output blink_short_off, output blink_even);
  modport dst (input blink_short_off, input blink_even);
endinterface

// file: include/oma_pkg.sv
// Types shared by the output mode arbiter modules
// Assumes oma_regs.svh for numbers
package oma_pkg;
  typedef logic signed [11:0] oma_val_t;
  typedef enum logic [2:0] {
    OMA_AUTO = 3'b000,
    OMA_MANUAL = 3'b001,
    OMA_FOLLOW = 3'b010,
    OMA_SAFE = 3'b011,
    OMA_BLOCK = 3'b100
  } oma_mode_t;
endpackage

// file: include/oma_regs.svh
// Offsets, field positions, reset values and timing for the output mode arbiter
// Assumes values in tenths of a percent, signed 12 bit
`ifndef OMA_REGS_SVH
`define OMA_REGS_SVH
`define OMA_ADR_CFG 2'h0
`define OMA_ADR_SAFE 2'h1
`define OMA_ADR_SER 2'h2
`define OMA_ADR_STAT 2'h3
`define OMA_CFG_PRIO 0
`define OMA_CFG_SRC 1
`define OMA_CFG_FLT 3:2
`define OMA_CFG_LOCK 5:4
`define OMA_CFG_DISP 7:6
`define OMA_CFG_SER 9:8
`define OMA_CFG_STR 11:10
`define OMA_CFG_RST 12'h000
`define OMA_SAFE_RST 12'h000
`define OMA_VAL_MIN 12'hf9c
`define OMA_VAL_MAX 12'h44c
`define OMA_VAL_HALF 12'h1f4
`define OMA_FULL_SCALE 12'h3e8
`define OMA_FLOAT_TIME_MS 60000
`define OMA_BLINK_STEP_MS 100
`define OMA_CLK_KHZ 20000
`define OMA_BLINK_SLOTS 4'h9
`endif

// file: tb/oma_tb.sv
// Self-checking bench for the output mode arbiter
// Assumes oma_arbiter on one clock, shortened ramp and blink dividers
`timescale 1ns/100ps
`include "oma_regs.svh"
module tb import oma_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, rstn, cyc, stb, we, ack, emr, fur, sfr, brr, blr, sup, sdn, flt, km, ku, kd;
  logic [3:0] adr, sel;
  logic [31:0] dat, dato, q;
  oma_val_t av, fa, pf, y, dv;
  logic sr, sl, mled, eled, mm, mf, don;
  int error_cnt, tests_run, n;
  oma_val_t p;
  oma_arbiter #(.RAMP_DIV(4), .BLINK_DIV(4)) uut (.CLOCK(clk), .RSTN(rstn), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dato), .ACK_O(ack), .EXT_MANUAL_REQ(emr),
    .FOLLOWUP_REQ(fur), .SAFETY_REQ(sfr), .BLOCK_RAISE_REQ(brr), .BLOCK_LOWER_REQ(blr), .STEP_UP_IN(sup),
    .STEP_DN_IN(sdn), .XMTR_FAULT(flt), .KEY_MANUAL(km), .KEY_UP(ku), .KEY_DN(kd), .AUTOMATIC_VALUE(av),
    .FOLLOWUP_ANALOG_INPUT(fa), .POSITION_FEEDBACK_INPUT(pf), .Y_OUT(y), .STEP_RAISE(sr), .STEP_LOWER(sl),
    .MANUAL_LED(mled), .EXT_LED(eled), .MODE_MANUAL(mm), .MODE_FOLLOWUP(mf), .DISPLAY_VALUE(dv),
    .DISPLAY_ON(don));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check(1'b0, 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [3:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask
  task settle();
    repeat (6) @(posedge clk);
  endtask
  task count40(input logic led_sel);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += led_sel ? int'(eled) : int'(mled);
    end
    @(posedge clk);
  endtask
  task key();
    @(posedge clk);
    km <= 1'b1;
    repeat (4) @(posedge clk);
    km <= 1'b0;
    settle();
  endtask
  // ----------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    error_cnt++;
    finish_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {cyc, stb, we, emr, fur, sfr, brr, blr, sup, sdn, flt, km, ku, kd} = '0;
    adr = 4'h0;
    sel = 4'h0;
    dat = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    av = 12'h064;
    fa = 12'h150;
    pf = 12'h123;
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h0);
    check(q, 32'h0);
    rd(4'h4);
    check(q, 32'h0);
    settle();
    wr(4'hc, 32'h0fff);
    rd(4'hc);
    check(q, 32'h0064);
    // Manual by external request, bumpless, release
    emr <= 1'b1;
    settle();
    av <= 12'h200;
    settle();
    check(mm, 1'b1);
    check(y, 12'h064);
    count40(1'b0);
    check(n, 32'h24);
    emr <= 1'b0;
    settle();
    check({mm, y}, {1'b0, 12'h200});
    // Follow-up against manual, both priorities
    fur <= 1'b1;
    emr <= 1'b1;
    settle();
    check({mf, mm, eled, y}, {3'b101, 12'h150});
    rd(4'hc);
    check(q[14:12], 3'h2);
    wr(4'h0, 32'h1);
    settle();
    check({mm, mf}, 2'b10);
    count40(1'b1);
    check(n, 32'h14);
    emr <= 1'b0;
    settle();
    check({mm, mf}, 2'b01);
    // External value sources
    wr(4'h0, 32'h200);
    wr(4'h8, 32'h0fa);
    settle();
    check(y, 12'h0fa);
    wr(4'h0, 32'h002);
    settle();
    p = y;
    sup <= 1'b1;
    repeat (40) @(posedge clk);
    sup <= 1'b0;
    settle();
    check((y - p) >= 12'sh009 && (y - p) <= 12'sh00b, 1'b1);
    p = y;
    wr(4'h0, 32'h400);
    settle();
    check(y, p);
    fur <= 1'b0;
    // Safety in step structure, then clamp in continuous
    wr(4'h4, 32'h12c);
    sfr <= 1'b1;
    settle();
    check({sl, sr, eled, mm, mf}, 5'b10100);
    rd(4'hc);
    check(q[14:12], 3'h3);
    wr(4'h4, 32'h258);
    settle();
    check({sl, sr}, 2'b01);
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h7d0);
    settle();
    check(y, 12'h44c);
    wb(1'b1, 4'h4, 32'h100, 4'h1);
    rd(4'h4);
    check(q[11:0], 12'h44c);
    // Blocking
    brr <= 1'b1;
    blr <= 1'b1;
    settle();
    rd(4'hc);
    check(q[14:12], 3'h4);
    av <= 12'h010;
    settle();
    check(y, 12'h44c);
    sfr <= 1'b0;
    blr <= 1'b0;
    av <= 12'h4a0;
    settle();
    check({eled, y}, {1'b1, 12'h44c});
    av <= 12'h300;
    settle();
    check(y, 12'h300);
    brr <= 1'b0;
    settle();
    // Transmitter fault starts manual from safety value
    wr(4'h0, 32'h008);
    wr(4'h4, 32'h0c8);
    flt <= 1'b1;
    settle();
    check({mm, y}, {1'b1, 12'h0c8});
    flt <= 1'b0;
    settle();
    // Display sources
    wr(4'h0, 32'h040);
    settle();
    check({don, dv}, {1'b1, 12'h300});
    wr(4'h0, 32'h080);
    settle();
    check({don, dv}, {1'b1, 12'h3e8});
    wr(4'h0, 32'h0c0);
    settle();
    check({don, dv}, {1'b1, 12'h123});
    wr(4'h0, 32'h0);
    settle();
    check(don, 1'b0);
    // Lockout and front key
    wr(4'h0, 32'h010);
    key();
    check(mm, 1'b0);
    wr(4'h0, 32'h0);
    key();
    check({mm, mled}, 2'b11);
    wr(4'h0, 32'h020);
    key();
    check({mm, mled}, 2'b11);
    // Manual keys: absolute ramp, then step increments
    p = y;
    ku <= 1'b1;
    repeat (12) @(posedge clk);
    check({sr, sl}, 2'b00);
    repeat (28) @(posedge clk);
    ku <= 1'b0;
    settle();
    check((y - p) >= 12'sh009 && (y - p) <= 12'sh00b, 1'b1);
    wr(4'h0, 32'h420);
    ku <= 1'b1;
    settle();
    check({sr, sl}, 2'b10);
    ku <= 1'b0;
    // Reset in mid-run returns to automatic
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    settle();
    rd(4'hc);
    check(q, 32'h0300);
    finish_test();
  end
endmodule // tb
